// ===== common/trap_seq_pkg.sv
// Package: constants, enums and carrier structs of the trap and interrupt sequencer
package trap_seq_pkg;
	localparam logic [3:0]  REG_CTRL        = 4'h0;
	localparam logic [3:0]  REG_STATUS      = 4'h4;
	localparam logic [3:0]  REG_REASON      = 4'h8;
	localparam int          CTRL_BUS16      = 0;
	localparam int          CTRL_MODE_LO    = 1;
	localparam logic [2:0]  CTRL_RESET      = 3'h0;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;
	localparam int          MSW_SS_BIT      = 8;
	localparam int          MSW_SSP_BIT     = 9;
	localparam int          MSW_HALT_EN_BIT = 10;
	localparam int          MSW_USER_BIT    = 14;
	localparam logic [15:0] MSW_IRQ_EN_MASK = 16'h007f;
	localparam logic [1:0]  IRQ_A           = 2'h0;
	localparam logic [1:0]  IRQ_NMI         = 2'h1;
	localparam logic [1:0]  IRQ_B           = 2'h2;
	localparam logic [1:0]  IRQ_C           = 2'h3;
	localparam logic [1:0]  ST_ACK_PREFIX   = 2'h3;
	localparam logic [1:0]  MODE_0          = 2'h0;
	localparam logic [1:0]  MODE_1          = 2'h1;
	localparam logic [1:0]  MODE_2          = 2'h2;
	localparam logic [1:0]  MODE_3          = 2'h3;

	typedef enum logic [2:0] {
		SEQ_IDLE  = 3'b000,
		SEQ_ACK   = 3'b001,
		SEQ_PUSH  = 3'b010,
		SEQ_VECT  = 3'b011,
		SEQ_FATAL = 3'b100
	} seq_state_t;

	typedef enum logic [3:0] {
		CLS_NONE   = 4'b0000,
		CLS_EXTI   = 4'b0001,
		CLS_PRIV   = 4'b0010,
		CLS_SC     = 4'b0011,
		CLS_AV     = 4'b0100,
		CLS_SSO    = 4'b0101,
		CLS_DIV    = 4'b0110,
		CLS_STEP   = 4'b0111,
		CLS_HALT   = 4'b1000,
		CLS_INTEXT = 4'b1001,
		CLS_ONCHIP = 4'b1010
	} exc_class_t;

	typedef struct packed {
		logic        insn_start;
		logic        block_iter;
		logic        halt_insn;
		logic        trap_valid;
		exc_class_t  trap_kind;
		logic        operand_valid;
		logic [15:0] msw;
		logic [15:0] insn_addr;
		logic [15:0] next_addr;
		logic [15:0] operand_addr;
		logic [15:0] template_addr;
		logic [15:0] sc_imm;
	} exec_info_t;

	typedef struct packed {
		logic [3:0]  awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [3:0]  araddr;
		logic        arvalid;
		logic        rready;
	} axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_t;
endpackage : trap_seq_pkg

// ===== hw/trap_interrupt_sequencer.sv
// Design: exception sequencer with acknowledge cycles, status push and AXI4-Lite registers
// How it works
// RL1: Halt met with halt-breakpoint enable set raises the halt breakpoint trap.
// RL2: Halt breakpoint pushes the halt instruction address, then the status word.
// RL3: Extension trap pushes next address, status word, operand address if any, template.
// RL4: Supervisor call pushes next address, status word, 16-bit immediate reason code.
// RL5: Privileged, access and division traps push trapping address, then status word.
// RL6: Re-executed traps push the status word with step-pending cleared.
// RL7: Step-enable and step-pending are loaded from the vector table status word.
// RL8: Interrupts only between instructions or between block instruction iterations.
// RL9: Traps found during execution are served before pending interrupts.
// RL10: 8-bit bus type lines: A 00, nonmaskable 01, B 10, C 11.
// RL11: 8-bit bus skips acknowledge for nonmaskable modes 0-2 and maskable mode 1.
// RL12: 8-bit bus reads one byte on low data lines during acknowledge.
// RL13: Mode 0 maskable repeats acknowledge cycles until a complete instruction.
// RL14: 16-bit bus acknowledges every external interrupt, type on status lines.
// RL15: 16-bit bus reads a word; modes 2 and 3 use its low byte as vector.
// RL16: Acknowledge runs in system mode; system mode holds until service start.
// RL17: Modes 0-2 start in system mode; mode 3 takes table status word.
// RL18: On-chip interrupts use mode 3 without acknowledge; traps never acknowledge.
// RL19: Mode 3 pushes PC, status word, reason; modes 1-2 PC; mode 0 nonmaskable PC.
// RL20: External mode 3 reason is acknowledge data, upper byte zero on 8-bit bus.
// RL21: On-chip interrupt reason is the vector table offset of its entry.
// RL22: Saved PC is next address, or block instruction address between iterations.
// RL23: An access violation on any status push enters the fatal condition.
// RL24: At instruction start take step trap if pending, then copy step-enable.
// RL25: Mode 3 external, on-chip interrupts and traps fetch new status from table.
// RL26: Each exception is encoded once into a class that selects push and acknowledge.
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module trap_interrupt_sequencer
	import trap_seq_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire exec_info_t  exec_in,
	input  wire logic [3:0]  irq_ext_in,
	input  wire logic        irq_onchip_in,
	input  wire logic [15:0] onchip_offset_in,
	input  wire logic [7:0]  low_data_lines_in,
	input  wire logic [7:0]  high_data_lines_in,
	input  wire logic        ack_ready_in,
	input  wire logic        insn_complete_in,
	input  wire logic        push_ack_in,
	input  wire logic        push_fault_in,
	input  wire logic        vector_msw_valid_in,
	input  wire logic [15:0] vector_msw_in,
	input  wire axi_req_t    axi_in,
	output axi_rsp_t         axi_out,
	output logic             ack_cycle_out,
	output logic             addr_strobe_out,
	output logic             ack_type_low_line_out,
	output logic             ack_type_high_line_out,
	output logic [3:0]       bus_status_lines_out,
	output logic             push_valid_out,
	output logic [15:0]      push_data_out,
	output logic             vector_fetch_out,
	output logic [7:0]       irq_vector_out,
	output logic             system_mode_out,
	output logic             service_start_out,
	output logic [15:0]      service_msw_out,
	output logic             step_pending_out,
	output logic             fatal_out
);
	typedef struct packed {
		seq_state_t       st;
		exc_class_t       cls;
		logic [1:0]       irq_type;
		logic             as_phase;
		logic [3:0][15:0] words;
		logic [2:0]       n_words;
		logic [2:0]       idx;
		logic [15:0]      saved_pc;
		logic [15:0]      saved_msw;
		logic [15:0]      reason;
		logic [7:0]       vector;
		logic             step_pending;
		logic             sys_mode;
		logic             fatal;
		logic             vec_req;
		logic             svc_start;
		logic [15:0]      svc_msw;
		logic [2:0]       ctrl;
		logic             aw_got;
		logic             w_got;
		logic [3:0]       aw_addr;
		logic [7:0]       w_byte;
		logic             w_lane0;
		axi_rsp_t         axi;
		logic             ack_cycle;
		logic             addr_strobe;
		logic [1:0]       ack_type;
		logic [3:0]       bus_status;
		logic             push_valid;
		logic [15:0]      push_data;
	} core_state_t;

	core_state_t s;
	core_state_t next_s;

	// Classes whose new status word and PC come from the vector table
	function automatic logic uses_table(input exc_class_t c, input logic [1:0] m);
		uses_table = (c == CLS_ONCHIP) || (c == CLS_INTEXT && m == MODE_3) ||
			(c != CLS_INTEXT && c != CLS_NONE); // RL25
	endfunction : uses_table

	// Re-executed traps: pushed status word loses its step-pending bit
	function automatic logic reexec(input exc_class_t c);
		reexec = (c == CLS_PRIV) || (c == CLS_AV) || (c == CLS_DIV) || (c == CLS_HALT); // RL6
	endfunction : reexec

	logic       bus16;
	logic [1:0] int_mode;
	logic       boundary;
	logic       halt_bp;
	logic [1:0] pick;
	logic       any_ext;
	logic       need_ack;
	logic [15:0] cur_msw;
	logic [15:0] ack_word;

	always_comb begin
		bus16    = s.ctrl[CTRL_BUS16];
		int_mode = s.ctrl[CTRL_MODE_LO +: 2];
		boundary = exec_in.insn_start || exec_in.block_iter; // RL8
		halt_bp  = exec_in.halt_insn && exec_in.msw[MSW_HALT_EN_BIT]; // RL1
		any_ext  = |irq_ext_in;
		// Nonmaskable wins, then A, B, C; on-chip requests come after all external ones
		if (irq_ext_in[IRQ_NMI]) begin
			pick = IRQ_NMI;
		end else if (irq_ext_in[IRQ_A]) begin
			pick = IRQ_A;
		end else if (irq_ext_in[IRQ_B]) begin
			pick = IRQ_B;
		end else begin
			pick = IRQ_C;
		end
		need_ack = bus16 || // RL14
			!((pick == IRQ_NMI && int_mode != MODE_3) ||
			(pick != IRQ_NMI && int_mode == MODE_1)); // RL11
		cur_msw = exec_in.msw;
		cur_msw[MSW_SSP_BIT] = s.step_pending;
		ack_word = bus16 ? {high_data_lines_in, low_data_lines_in}
			: {8'h00, low_data_lines_in}; // RL12 RL20
	end

	always_comb begin
		next_s = s;
		next_s.svc_start = 1'b0;
		next_s.addr_strobe = 1'b0;
		case (s.st)
			SEQ_IDLE: begin
				if (exec_in.trap_valid || halt_bp) begin // RL9
					next_s.cls = halt_bp ? CLS_HALT : exec_in.trap_kind; // RL26
					next_s.saved_msw = reexec(next_s.cls) ?
						(cur_msw & ~(16'h0001 << MSW_SSP_BIT)) : cur_msw; // RL6
					next_s.words[1] = next_s.saved_msw;
					next_s.n_words = 3'h2;
					if (reexec(next_s.cls)) begin
						next_s.words[0] = exec_in.insn_addr; // RL2 RL5
					end else begin
						next_s.words[0] = exec_in.next_addr;
					end
					if (next_s.cls == CLS_SC) begin
						next_s.words[2] = exec_in.sc_imm; // RL4
						next_s.n_words = 3'h3;
					end else if (next_s.cls == CLS_EXTI) begin
						if (exec_in.operand_valid) begin // RL3
							next_s.words[2] = exec_in.operand_addr;
							next_s.words[3] = exec_in.template_addr;
							next_s.n_words = 3'h4;
						end else begin
							next_s.words[2] = exec_in.template_addr;
							next_s.n_words = 3'h3;
						end
					end
					next_s.idx = 3'h0;
					next_s.sys_mode = 1'b1;
					next_s.push_valid = 1'b1; // RL18
					next_s.st = SEQ_PUSH;
					if (exec_in.insn_start) begin
						next_s.step_pending = exec_in.msw[MSW_SS_BIT]; // RL24
					end
				end else if (exec_in.insn_start && s.step_pending) begin
					next_s.cls = CLS_STEP; // RL24
					next_s.saved_msw = cur_msw & ~(16'h0001 << MSW_SSP_BIT);
					next_s.words[0] = exec_in.insn_addr;
					next_s.words[1] = next_s.saved_msw;
					next_s.n_words = 3'h2;
					next_s.idx = 3'h0;
					next_s.sys_mode = 1'b1;
					next_s.push_valid = 1'b1;
					next_s.step_pending = exec_in.msw[MSW_SS_BIT];
					next_s.st = SEQ_PUSH;
				end else begin
					if (exec_in.insn_start) begin
						next_s.step_pending = exec_in.msw[MSW_SS_BIT]; // RL24
					end
					if (boundary && (any_ext || irq_onchip_in)) begin // RL8
						// Block instruction resumes from its own address
						next_s.saved_pc = exec_in.block_iter ?
							exec_in.insn_addr : exec_in.next_addr; // RL22
						next_s.saved_msw = cur_msw;
						next_s.sys_mode = 1'b1; // RL16
						next_s.idx = 3'h0;
						next_s.n_words = 3'h0;
						if (any_ext) begin
							next_s.cls = CLS_INTEXT;
							next_s.irq_type = pick;
							next_s.reason = 16'h0000;
							if (need_ack) begin
								next_s.st = SEQ_ACK;
								next_s.as_phase = 1'b1;
								next_s.addr_strobe = 1'b1;
								next_s.ack_cycle = 1'b1;
								next_s.ack_type = pick; // RL10
								next_s.bus_status = {ST_ACK_PREFIX, pick}; // RL14
							end else begin
								next_s.st = SEQ_PUSH;
							end
						end else begin
							next_s.cls = CLS_ONCHIP; // RL18
							next_s.reason = onchip_offset_in; // RL21
							next_s.st = SEQ_PUSH;
						end
					end
				end
			end
			SEQ_ACK: begin
				next_s.as_phase = 1'b0;
				if (!s.as_phase && ack_ready_in) begin
					next_s.reason = ack_word; // RL20
					if (int_mode == MODE_2 || int_mode == MODE_3) begin
						next_s.vector = ack_word[7:0]; // RL15
					end
					if (int_mode == MODE_0 && s.irq_type != IRQ_NMI && !insn_complete_in) begin
						next_s.as_phase = 1'b1; // RL13
						next_s.addr_strobe = 1'b1;
					end else begin
						next_s.ack_cycle = 1'b0;
						next_s.st = SEQ_PUSH;
					end
				end
			end
			SEQ_PUSH: begin
				// Interrupt words are built here so the acknowledge data is already held
				if (s.cls == CLS_INTEXT || s.cls == CLS_ONCHIP) begin
					if (s.n_words == 3'h0 && !s.push_valid) begin
						next_s.words[0] = s.saved_pc;
						next_s.words[1] = s.saved_msw;
						next_s.words[2] = s.reason;
						if (s.cls == CLS_ONCHIP || int_mode == MODE_3) begin
							next_s.n_words = 3'h3; // RL19
						end else if (int_mode == MODE_0 && s.irq_type != IRQ_NMI) begin
							next_s.n_words = 3'h0;
						end else begin
							next_s.n_words = 3'h1;
						end
						next_s.push_valid = (next_s.n_words != 3'h0);
						next_s.idx = 3'h0;
						if (next_s.n_words == 3'h0) begin
							next_s.st = SEQ_VECT;
						end
					end
				end
				if (s.push_valid && push_ack_in) begin
					if (push_fault_in) begin
						next_s.push_valid = 1'b0;
						next_s.fatal = 1'b1; // RL23
						next_s.st = SEQ_FATAL;
					end else if (s.idx + 3'h1 == s.n_words) begin
						next_s.push_valid = 1'b0;
						next_s.st = SEQ_VECT;
					end else begin
						next_s.idx = s.idx + 3'h1;
					end
				end
				if (next_s.st == SEQ_VECT && uses_table(s.cls, int_mode)) begin
					next_s.vec_req = 1'b1; // RL25
				end
			end
			SEQ_VECT: begin
				if (!s.vec_req) begin
					// Modes 0-2: system mode, stepping and maskable enables cleared
					next_s.svc_msw = s.saved_msw & ~MSW_IRQ_EN_MASK &
						~(16'h0001 << MSW_USER_BIT) & ~(16'h0001 << MSW_SS_BIT) &
						~(16'h0001 << MSW_SSP_BIT); // RL17
					next_s.svc_start = 1'b1;
					next_s.sys_mode = 1'b0;
					next_s.st = SEQ_IDLE;
				end else if (vector_msw_valid_in) begin
					next_s.vec_req = 1'b0;
					next_s.svc_msw = vector_msw_in; // RL17
					next_s.step_pending = vector_msw_in[MSW_SSP_BIT]; // RL7
					next_s.svc_start = 1'b1;
					next_s.sys_mode = 1'b0; // RL16
					next_s.st = SEQ_IDLE;
				end
			end
			SEQ_FATAL: begin
				// Held until reset; no further exceptions are taken
				next_s.fatal = 1'b1;
			end
			default: begin
				next_s.st = SEQ_IDLE;
			end
		endcase
		next_s.push_data = next_s.words[next_s.idx[1:0]];

		// AXI4-Lite slave; address and data are taken in either order
		if (axi_in.awvalid && s.axi.awready) begin
			next_s.aw_got = 1'b1;
			next_s.aw_addr = axi_in.awaddr;
		end
		if (axi_in.wvalid && s.axi.wready) begin
			next_s.w_got = 1'b1;
			next_s.w_byte = axi_in.wdata[7:0];
			next_s.w_lane0 = axi_in.wstrb[0];
		end
		if (s.axi.bvalid && axi_in.bready) begin
			next_s.axi.bvalid = 1'b0;
		end
		if (next_s.aw_got && next_s.w_got && !next_s.axi.bvalid) begin
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.axi.bvalid = 1'b1;
			next_s.axi.bresp = RESP_SLVERR;
			if ({next_s.aw_addr[3:2], 2'b00} == REG_CTRL) begin
				next_s.axi.bresp = RESP_OKAY;
				if (next_s.w_lane0) begin
					next_s.ctrl = next_s.w_byte[2:0];
				end
			end else if ({next_s.aw_addr[3:2], 2'b00} == REG_STATUS ||
				{next_s.aw_addr[3:2], 2'b00} == REG_REASON) begin
				next_s.axi.bresp = RESP_OKAY;
			end
		end
		next_s.axi.awready = !next_s.aw_got;
		next_s.axi.wready = !next_s.w_got;
		if (s.axi.rvalid && axi_in.rready) begin
			next_s.axi.rvalid = 1'b0;
		end
		if (axi_in.arvalid && s.axi.arready) begin
			next_s.axi.rvalid = 1'b1;
			next_s.axi.rresp = RESP_OKAY;
			case ({axi_in.araddr[3:2], 2'b00})
				REG_CTRL: next_s.axi.rdata = {29'h0, s.ctrl};
				REG_STATUS: next_s.axi.rdata = {16'h0, s.step_pending, s.sys_mode,
					s.fatal, s.ack_cycle, s.cls, s.irq_type, s.vec_req, s.push_valid,
					1'b0, s.st};
				REG_REASON: next_s.axi.rdata = {8'h0, s.vector, s.reason};
				default: begin
					next_s.axi.rdata = 32'h0;
					next_s.axi.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_s.axi.arready = !next_s.axi.rvalid;
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		axi_out                = s.axi;
		ack_cycle_out          = s.ack_cycle;
		addr_strobe_out        = s.addr_strobe;
		ack_type_low_line_out  = s.ack_type[0];
		ack_type_high_line_out = s.ack_type[1];
		bus_status_lines_out   = s.bus_status;
		push_valid_out         = s.push_valid;
		push_data_out          = s.push_data;
		vector_fetch_out       = s.vec_req;
		irq_vector_out         = s.vector;
		system_mode_out        = s.sys_mode;
		service_start_out      = s.svc_start;
		service_msw_out        = s.svc_msw;
		step_pending_out       = s.step_pending;
		fatal_out              = s.fatal;
	end

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_halt_bp;
		s.st == SEQ_IDLE && halt_bp |=> s.st == SEQ_PUSH && s.cls == CLS_HALT && !s.ack_cycle;
	endproperty
	a_halt_bp: assert property (p_halt_bp) else $error("halt breakpoint not raised"); // RL1

	property p_halt_push;
		s.st == SEQ_IDLE && halt_bp |=> push_data_out == $past(exec_in.insn_addr);
	endproperty
	a_halt_push: assert property (p_halt_push) else $error("halt address not pushed"); // RL2

	property p_ssp_clear;
		s.st == SEQ_PUSH && s.push_valid && s.idx == 3'h1 && reexec(s.cls)
			|-> !push_data_out[MSW_SSP_BIT];
	endproperty
	a_ssp_clear: assert property (p_ssp_clear) else $error("pushed step-pending set"); // RL6

	property p_step_copy;
		s.st == SEQ_IDLE && exec_in.insn_start
			|=> step_pending_out == $past(exec_in.msw[MSW_SS_BIT]);
	endproperty
	a_step_copy: assert property (p_step_copy) else $error("step bit not copied"); // RL24

	property p_no_ack_onchip;
		s.cls == CLS_ONCHIP || (s.cls != CLS_INTEXT && s.st == SEQ_PUSH) |-> !ack_cycle_out;
	endproperty
	a_no_ack_onchip: assert property (p_no_ack_onchip) else $error("unexpected ack"); // RL18

	property p_ack_type;
		addr_strobe_out |-> {ack_type_high_line_out, ack_type_low_line_out} == s.irq_type &&
			bus_status_lines_out == {ST_ACK_PREFIX, s.irq_type};
	endproperty
	a_ack_type: assert property (p_ack_type) else $error("ack type lines wrong"); // RL10

	property p_fatal;
		s.st == SEQ_PUSH && push_valid_out && push_ack_in && push_fault_in
			|=> fatal_out && !push_valid_out ##1 fatal_out;
	endproperty
	a_fatal: assert property (p_fatal) else $error("fatal not entered"); // RL23

	property p_sys_mode;
		s.st == SEQ_ACK || s.st == SEQ_PUSH |-> system_mode_out;
	endproperty
	a_sys_mode: assert property (p_sys_mode) else $error("system mode dropped"); // RL16

	property p_reason8;
		s.cls == CLS_INTEXT && !bus16 && s.st == SEQ_PUSH |-> s.reason[15:8] == 8'h00;
	endproperty
	a_reason8: assert property (p_reason8) else $error("reason upper byte set"); // RL20
endmodule : trap_interrupt_sequencer

// ===== dv/ack_peripheral_model.sv
// Peripheral model that answers acknowledge cycles on the data lines
`timescale 1ns/1ps
module ack_peripheral_model #(
	parameter int         DELAY  = 2,
	parameter int         NBYTES = 3,
	parameter logic [7:0] BASE   = 8'ha0
) (
	input  wire logic       core_clk_in,
	input  wire logic       ack_cycle_in,
	input  wire logic       addr_strobe_in,
	output logic [7:0]      low_data_out,
	output logic [7:0]      high_data_out,
	output logic            ready_out,
	output logic            complete_out
);
	int         strobes  = 0;
	int         wait_cnt = 0;
	logic [7:0] byte_now;
	// A slow peripheral: data is only valid after DELAY cycles of each ack cycle
	always @(posedge core_clk_in) begin
		if (!ack_cycle_in) begin
			strobes <= 0;
			wait_cnt <= 0;
		end else if (addr_strobe_in) begin
			strobes <= strobes + 1;
			wait_cnt <= 0;
		end else begin
			wait_cnt <= wait_cnt + 1;
		end
	end
	assign byte_now = BASE + 8'(strobes - 1);
	assign ready_out = ack_cycle_in && !addr_strobe_in && strobes > 0 && wait_cnt >= DELAY;
	// Released bus shows the inverse, so a stale byte is never mistaken for data
	assign low_data_out = ready_out ? byte_now : ~byte_now;
	assign high_data_out = ready_out ? 8'hc3 : 8'h3c;
	assign complete_out = ready_out && strobes == NBYTES;
endmodule : ack_peripheral_model

// ===== dv/trap_interrupt_sequencer_test.sv
// Self-checking testbench of the trap and interrupt sequencer
`timescale 1ns/1ps
module trap_interrupt_sequencer_test;
	import trap_seq_pkg::*;
	logic        core_clk_in = 0, rst_n_in = 0, irq_onchip_in = 0, push_ack_in = 0;
	logic        push_fault_in = 0, vector_msw_valid_in = 0;
	logic        ack_ready_in, insn_complete_in, ack_cycle_out, addr_strobe_out;
	logic        ack_type_low_line_out, ack_type_high_line_out, push_valid_out;
	logic        vector_fetch_out, system_mode_out, service_start_out, step_pending_out;
	logic        fatal_out, seen_ack;
	logic [1:0]  resp, typ_seen;
	logic [3:0]  irq_ext_in = 0, bus_status_lines_out, st_seen;
	logic [7:0]  low_data_lines_in, high_data_lines_in, irq_vector_out;
	logic [15:0] onchip_offset_in = 16'h0014, vector_msw_in = 0, push_data_out, service_msw_out;
	logic [31:0] rd;
	exec_info_t  exec_in = '0;
	axi_req_t    axi_in = '0;
	axi_rsp_t    axi_out;
	int          fails = 0, tests_run = 0, cycles = 0, strobes = 0;
	exc_class_t  kinds[7] = '{CLS_PRIV, CLS_AV, CLS_DIV, CLS_SC, CLS_EXTI, CLS_SSO, CLS_NONE};
	int          nw[7] = '{2, 2, 2, 3, 4, 2, 2};
	logic [63:0] tw[7] = '{64'h1000_047f_0000_0000, 64'h1000_047f_0000_0000,
		64'h1000_047f_0000_0000, 64'h1004_047f_beef_0000, 64'h1004_047f_2000_3000,
		64'h1004_047f_0000_0000, 64'h1000_047f_0000_0000};

	trap_interrupt_sequencer u_trap_interrupt_sequencer (.core_clk_in, .rst_n_in, .exec_in,
		.irq_ext_in, .irq_onchip_in, .onchip_offset_in, .low_data_lines_in,
		.high_data_lines_in, .ack_ready_in, .insn_complete_in, .push_ack_in, .push_fault_in,
		.vector_msw_valid_in, .vector_msw_in, .axi_in, .axi_out, .ack_cycle_out,
		.addr_strobe_out, .ack_type_low_line_out, .ack_type_high_line_out,
		.bus_status_lines_out, .push_valid_out, .push_data_out, .vector_fetch_out,
		.irq_vector_out, .system_mode_out, .service_start_out, .service_msw_out,
		.step_pending_out, .fatal_out);
	ack_peripheral_model u_ack_peripheral_model (.core_clk_in, .ack_cycle_in(ack_cycle_out),
		.addr_strobe_in(addr_strobe_out), .low_data_out(low_data_lines_in),
		.high_data_out(high_data_lines_in), .ready_out(ack_ready_in),
		.complete_out(insn_complete_in));

	always #5 core_clk_in = ~core_clk_in;
	always @(negedge core_clk_in) begin
		if (ack_cycle_out) seen_ack = 1'b1;
		if (addr_strobe_out) begin
			strobes++;
			typ_seen = {ack_type_high_line_out, ack_type_low_line_out};
			st_seen = bus_status_lines_out;
		end
	end
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		axi_in.awaddr <= a;
		axi_in.wdata <= d;
		axi_in.wstrb <= 4'hf;
		axi_in.awvalid <= 1;
		axi_in.wvalid <= 1;
		axi_in.bready <= 1;
		for (int n = 0; n < 50; n++) begin
			@(posedge core_clk_in);
			if (axi_out.awready) axi_in.awvalid <= 0;
			if (axi_out.wready) axi_in.wvalid <= 0;
			if (axi_out.bvalid) break;
		end
		resp = axi_out.bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a);
		axi_in.araddr <= a;
		axi_in.arvalid <= 1;
		axi_in.rready <= 1;
		for (int n = 0; n < 50; n++) begin
			@(posedge core_clk_in);
			if (axi_out.arready) axi_in.arvalid <= 0;
			if (axi_out.rvalid) break;
		end
		rd = axi_out.rdata;
		resp = axi_out.rresp;
	endtask : axi_rd
	// Serves stack pushes and the table fetch until the service routine starts
	task automatic run(input int n, input logic [63:0] w, input logic [15:0] sm);
		int got;
		got = 0;
		for (int k = 0; k < 300; k++) begin
			@(negedge core_clk_in);
			if (service_start_out) break;
			if (push_valid_out) begin
				chk(system_mode_out, 1);
				if (got < 4) chk(push_data_out, w[63 - 16 * got -: 16]);
				got++;
				@(posedge core_clk_in);
				push_ack_in <= 1;
				@(posedge core_clk_in);
				push_ack_in <= 0;
			end else if (vector_fetch_out) begin
				@(posedge core_clk_in);
				vector_msw_valid_in <= 1;
				@(posedge core_clk_in);
				vector_msw_valid_in <= 0;
			end
		end
		chk(got, n);
		chk(service_start_out, 1);
		chk(service_msw_out, sm);
	endtask : run
	task automatic irq(input logic [2:0] c, input logic [3:0] rq, input logic oc,
		input logic blk, input logic ack, input logic [1:0] ty, input int n,
		input logic [63:0] w, input logic [15:0] sm);
		@(posedge core_clk_in);
		axi_wr(REG_CTRL, {29'h0, c});
		seen_ack = 0;
		strobes = 0;
		vector_msw_in <= sm;
		irq_ext_in <= rq;
		irq_onchip_in <= oc;
		exec_in.insn_start <= !blk;
		exec_in.block_iter <= blk;
		@(posedge core_clk_in);
		exec_in.insn_start <= 0;
		exec_in.block_iter <= 0;
		run(n, w, sm);
		@(posedge core_clk_in);
		irq_ext_in <= 0;
		irq_onchip_in <= 0;
		chk(seen_ack, ack);
		if (ack) chk(c[0] ? st_seen : typ_seen, c[0] ? {ST_ACK_PREFIX, ty} : ty);
	endtask : irq

	initial begin
		repeat (2) @(posedge core_clk_in);
		chk({axi_out.awready, push_valid_out, fatal_out}, 0);
		rst_n_in <= 1;
		repeat (2) @(posedge core_clk_in);
		axi_rd(REG_CTRL);
		chk(rd, CTRL_RESET);
		axi_rd(4'hc);
		chk(resp, RESP_SLVERR);
		axi_wr(REG_CTRL, 32'h7);
		chk(resp, RESP_OKAY);
		axi_rd(REG_CTRL);
		chk(rd, 32'h7);
		axi_wr(REG_CTRL, 32'h0);
		exec_in <= '{insn_addr: 16'h1000, next_addr: 16'h1004, operand_addr: 16'h2000,
			template_addr: 16'h3000, sc_imm: 16'hbeef, msw: 16'h067f, operand_valid: 1,
			trap_kind: CLS_NONE, default: 0};
		// A pending boundary interrupt rides along with every trap
		for (int i = 0; i < 7; i++) begin
			@(posedge core_clk_in);
			seen_ack = 0;
			irq_ext_in <= 4'h1;
			exec_in.trap_kind <= kinds[i];
			exec_in.trap_valid <= kinds[i] != CLS_NONE;
			exec_in.halt_insn <= kinds[i] == CLS_NONE;
			exec_in.block_iter <= 1;
			@(posedge core_clk_in);
			exec_in.trap_valid <= 0;
			exec_in.halt_insn <= 0;
			exec_in.block_iter <= 0;
			run(nw[i], tw[i], 16'h0000);
			@(posedge core_clk_in);
			irq_ext_in <= 0;
			chk(seen_ack, 0);
		end
		exec_in.msw <= 16'h407f;
		irq(3'b110, 4'h8, 0, 0, 1, IRQ_C, 3, 64'h1004_407f_00a0_0000, 16'h0080);
		irq(3'b010, 4'h1, 0, 0, 0, IRQ_A, 1, 64'h1004_0000_0000_0000, 16'h0000);
		irq(3'b000, 4'h2, 0, 0, 0, IRQ_NMI, 1, 64'h1004_0000_0000_0000, 16'h0000);
		irq(3'b100, 4'h4, 0, 1, 1, IRQ_B, 1, 64'h1000_0000_0000_0000, 16'h0000);
		irq(3'b110, 4'h2, 0, 0, 1, IRQ_NMI, 3, 64'h1004_407f_00a0_0000, 16'h0080);
		irq(3'b101, 4'h4, 0, 0, 1, IRQ_B, 1, 64'h1004_0000_0000_0000, 16'h0000);
		chk(irq_vector_out, 8'ha0);
		irq(3'b111, 4'h1, 0, 0, 1, IRQ_A, 3, 64'h1004_407f_c3a0_0000, 16'h0080);
		irq(3'b000, 4'h1, 0, 0, 1, IRQ_A, 0, 64'h0, 16'h0000);
		chk(strobes, 3);
		irq(3'b010, 4'h0, 1, 0, 0, IRQ_A, 3, 64'h1004_407f_0014_0000, 16'h0300);
		chk(step_pending_out, 1);
		// Pending step trap at the next start; the table word keeps stepping armed
		@(posedge core_clk_in);
		exec_in.insn_start <= 1;
		@(posedge core_clk_in);
		exec_in.insn_start <= 0;
		run(2, 64'h1000_407f_0000_0000, 16'h0300);
		@(posedge core_clk_in);
		exec_in.trap_kind <= CLS_PRIV;
		exec_in.trap_valid <= 1;
		@(posedge core_clk_in);
		exec_in.trap_valid <= 0;
		for (int k = 0; k < 50 && !push_valid_out; k++) @(negedge core_clk_in);
		@(posedge core_clk_in);
		push_ack_in <= 1;
		@(posedge core_clk_in);
		push_ack_in <= 0;
		@(negedge core_clk_in);
		chk(push_data_out, 16'h407f);
		@(posedge core_clk_in);
		push_ack_in <= 1;
		push_fault_in <= 1;
		@(posedge core_clk_in);
		push_ack_in <= 0;
		push_fault_in <= 0;
		repeat (3) @(negedge core_clk_in);
		chk(fatal_out, 1);
		// Only a reset leaves the fatal condition
		@(posedge core_clk_in);
		rst_n_in <= 0;
		@(posedge core_clk_in);
		rst_n_in <= 1;
		repeat (2) @(posedge core_clk_in);
		chk({fatal_out, system_mode_out, step_pending_out}, 0);
		close_out();
	end
endmodule : trap_interrupt_sequencer_test
